// File: ispi_core.sv
// general channel of an spi master with apb registers and a link clock domain
// assumes apb master on ref_clk_i; link_clk_i is unrelated, free running
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`include "ispi_consts.svh"

module ispi_core
   import ispi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic link_clk_i,
   input wire logic ext_trigger_i,
   output logic sck_o,
   output logic select_one_o,
   output logic select_two_o,
   output logic mosi_o,
   output logic mosi_oe_o,
   input wire logic miso_i,
   output logic busy_o
);
   // ************************************
   // register file
   // ************************************
   logic enable_ff;
   logic trig_src_ff;
   ispi_job_s job_ff;
   logic [7:0] temp_start_ff;
   ispi_link_s link_one_ff;
   ispi_link_s link_two_ff;
   logic [7:0] tx_mem [0:`ISPI_TXBUF_DEPTH-1];
   logic [7:0] rx_mem [0:`ISPI_RXBUF_DEPTH-1];
   logic start_tgl_ff;
   logic done_s1_ff;
   logic done_s2_ff;
   logic done_seen_ff;
   logic busy_ff;
   logic ext_s1_ff;
   logic ext_s2_ff;
   logic ext_d_ff;
   logic [15:0] idx;
   logic acc;
   logic wr;
   logic start_req;

   function automatic logic [15:0] word_index(input logic [31:0] a);
      word_index = a[17:2];
   endfunction

   assign idx = word_index(paddr_i);
   assign acc = psel_i & penable_i & pready_o;
   assign wr = acc & pwrite_i;

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i & ~penable_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         enable_ff <= 1'b0;
         trig_src_ff <= 1'b0;
         job_ff <= '0;
         temp_start_ff <= 8'h00;
         link_one_ff <= '0;
         link_two_ff <= '0;
      end else if (wr) begin
         case (idx)
            `ISPI_IDX_ENABLE: enable_ff <= pwdata_i[0];
            `ISPI_IDX_TGTSEL: begin
               job_ff.target_select <= pwdata_i[`ISPI_TGTSEL_LO +: 2];
               trig_src_ff <= pwdata_i[`ISPI_TRIG_SRC_BIT];
            end
            `ISPI_IDX_REPEAT: job_ff.repeat_count <= pwdata_i[7:0];
            `ISPI_IDX_RXPTR: job_ff.rx_ptr <= pwdata_i[7:0];
            `ISPI_IDX_TXPTR: job_ff.tx_ptr <= pwdata_i[7:0];
            `ISPI_IDX_TXCNT: job_ff.tx_byte_count <= pwdata_i[7:0];
            `ISPI_IDX_TEMP: temp_start_ff <= pwdata_i[7:0];
            `ISPI_IDX_LINK1: link_one_ff <= {pwdata_i[`ISPI_B_RXDLY],
               pwdata_i[`ISPI_B_WIRE:`ISPI_B_CPHA]};
            `ISPI_IDX_LINK2: link_two_ff <= {pwdata_i[`ISPI_B_RXDLY],
               pwdata_i[`ISPI_B_WIRE:`ISPI_B_CPHA]};
            default: ;
         endcase
      end
   end

   // tx buffer written by software
   always_ff @(posedge ref_clk_i) begin
      if (wr && idx >= `ISPI_IDX_TXBUF && idx < `ISPI_IDX_TXBUF + `ISPI_TXBUF_DEPTH) begin
         tx_mem[6'(idx - `ISPI_IDX_TXBUF)] <= pwdata_i[7:0];
      end
   end

   // start: register trigger or synchronised external sync
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_d_ff <= 1'b0;
      end else begin
         ext_s1_ff <= ext_trigger_i;
         ext_s2_ff <= ext_s1_ff;
         ext_d_ff <= ext_s2_ff;
      end
   end

   assign start_req = enable_ff & ~busy_ff &
      ((~trig_src_ff & wr & (idx == `ISPI_IDX_START) & pwdata_i[0]) |
       (trig_src_ff & ext_s2_ff & ~ext_d_ff));

   logic link_done_tgl_ff;
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         start_tgl_ff <= 1'b0;
         busy_ff <= 1'b0;
         done_s1_ff <= 1'b0;
         done_s2_ff <= 1'b0;
         done_seen_ff <= 1'b0;
      end else begin
         done_s1_ff <= link_done_tgl_ff;
         done_s2_ff <= done_s1_ff;
         done_seen_ff <= done_s2_ff;
         if (start_req) begin
            start_tgl_ff <= ~start_tgl_ff;
            busy_ff <= 1'b1;
         end else if (done_s2_ff != done_seen_ff) begin
            busy_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         busy_o <= 1'b0;
      end else begin
         busy_o <= busy_ff;
      end
   end

   // read data; rx buffer is read only after busy clears, so it is stable
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && !penable_i) begin
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         case (idx)
            `ISPI_IDX_ENABLE: prdata_o[0] <= enable_ff;
            `ISPI_IDX_TGTSEL: prdata_o[7:0] <= {trig_src_ff, job_ff.target_select,
               5'b0_0000};
            `ISPI_IDX_REPEAT: prdata_o[7:0] <= job_ff.repeat_count;
            `ISPI_IDX_RXPTR: prdata_o[7:0] <= job_ff.rx_ptr;
            `ISPI_IDX_TXPTR: prdata_o[7:0] <= job_ff.tx_ptr;
            `ISPI_IDX_TXCNT: prdata_o[7:0] <= job_ff.tx_byte_count;
            `ISPI_IDX_TEMP: prdata_o[7:0] <= temp_start_ff;
            `ISPI_IDX_LINK1: prdata_o[7:0] <= {1'b0, link_one_ff.rx_delay, 1'b0,
               link_one_ff[4:0]};
            `ISPI_IDX_LINK2: prdata_o[7:0] <= {1'b0, link_two_ff.rx_delay, 1'b0,
               link_two_ff[4:0]};
            `ISPI_IDX_STATUS: prdata_o[0] <= busy_ff;
            `ISPI_IDX_START: ;
            default: begin
               if (idx >= `ISPI_IDX_RXBUF && idx < `ISPI_IDX_RXBUF + `ISPI_RXBUF_DEPTH) begin
                  prdata_o[7:0] <= rx_mem[4'(idx - `ISPI_IDX_RXBUF)];
               end else if (idx >= `ISPI_IDX_TXBUF &&
                  idx < `ISPI_IDX_TXBUF + `ISPI_TXBUF_DEPTH) begin
                  prdata_o[7:0] <= tx_mem[6'(idx - `ISPI_IDX_TXBUF)];
               end else begin
                  pslverr_o <= 1'b1;
               end
            end
         endcase
      end
   end

   // ************************************
   // link domain
   // ************************************
   // job settings are quasi-static while busy, so they are read directly
   logic st_s1_ff;
   logic st_s2_ff;
   logic st_seen_ff;
   ispi_state_e state_ff;
   ispi_link_s cfg_ff;
   logic sel_two_ff;
   logic [3:0] div_ff;
   logic [2:0] bit_ff;
   logic [7:0] rep_ff;
   logic [5:0] tx_idx_ff;
   logic [3:0] rx_idx_ff;
   logic [7:0] byte_n_ff;
   logic [7:0] sh_tx_ff;
   logic [7:0] sh_rx_ff;
   logic miso_s1_ff;
   logic miso_s2_ff;
   logic smp_pend_ff;
   logic [7:0] nbytes;
   logic bit_in;

   assign nbytes = job_ff.tx_byte_count;

   always_ff @(posedge link_clk_i) begin
      if (!rst_b_i) begin
         st_s1_ff <= 1'b0;
         st_s2_ff <= 1'b0;
         miso_s1_ff <= 1'b0;
         miso_s2_ff <= 1'b0;
      end else begin
         st_s1_ff <= start_tgl_ff;
         st_s2_ff <= st_s1_ff;
         miso_s1_ff <= miso_i;
         miso_s2_ff <= miso_s1_ff;
      end
   end

   // pick the bit position per order
   function automatic logic out_bit(input logic [7:0] b, input logic [2:0] n,
      input logic msb);
      out_bit = msb ? b[3'd7 - n] : b[n];
   endfunction

   assign bit_in = miso_s2_ff;

   always_ff @(posedge link_clk_i) begin
      if (!rst_b_i) begin
         state_ff <= ISPI_IDLE;
         st_seen_ff <= 1'b0;
         link_done_tgl_ff <= 1'b0;
         cfg_ff <= '0;
         sel_two_ff <= 1'b0;
         div_ff <= 4'h0;
         bit_ff <= 3'h0;
         rep_ff <= 8'h00;
         tx_idx_ff <= 6'h00;
         rx_idx_ff <= 4'h0;
         byte_n_ff <= 8'h00;
         sh_rx_ff <= 8'h00;
         smp_pend_ff <= 1'b0;
         sck_o <= 1'b0;
         select_one_o <= 1'b1;
         select_two_o <= 1'b1;
         mosi_o <= 1'b0;
         mosi_oe_o <= 1'b0;
      end else begin
         case (state_ff)
            ISPI_IDLE: begin
               sck_o <= cfg_ff.clock_polarity;
               select_one_o <= ~link_one_ff.select_polarity;
               select_two_o <= ~link_two_ff.select_polarity;
               mosi_oe_o <= 1'b0;
               if (st_s2_ff != st_seen_ff) begin
                  st_seen_ff <= st_s2_ff;
                  sel_two_ff <= (job_ff.target_select == `ISPI_TGT_TWO);
                  cfg_ff <= (job_ff.target_select == `ISPI_TGT_TWO) ? link_two_ff
                     : link_one_ff;
                  rep_ff <= job_ff.repeat_count;
                  sck_o <= (job_ff.target_select == `ISPI_TGT_TWO) ?
                     link_two_ff.clock_polarity : link_one_ff.clock_polarity;
                  state_ff <= ISPI_LEAD;
                  div_ff <= 4'h0;
               end
               if (st_s2_ff == st_seen_ff && state_ff == ISPI_IDLE) begin
                  cfg_ff <= link_one_ff;
               end
            end
            ISPI_LEAD: begin
               // each transaction restarts at the pointers
               tx_idx_ff <= job_ff.tx_ptr[5:0];
               rx_idx_ff <= job_ff.rx_ptr[3:0];
               byte_n_ff <= 8'h00;
               bit_ff <= 3'h0;
               sck_o <= cfg_ff.clock_polarity;
               if (job_ff.target_select != `ISPI_TGT_NONE) begin
                  select_one_o <= sel_two_ff ? ~link_one_ff.select_polarity
                     : link_one_ff.select_polarity;
                  select_two_o <= sel_two_ff ? link_two_ff.select_polarity
                     : ~link_two_ff.select_polarity;
               end
               sh_tx_ff <= tx_mem[job_ff.tx_ptr[5:0]];
               mosi_oe_o <= cfg_ff.wiring | (nbytes != 8'h00);
               mosi_o <= out_bit(tx_mem[job_ff.tx_ptr[5:0]], 3'h0, cfg_ff.bit_order);
               div_ff <= div_ff + 4'h1;
               if (div_ff == `ISPI_HALF_CYC) begin
                  div_ff <= 4'h0;
                  state_ff <= ISPI_FIRST;
                  sck_o <= ~cfg_ff.clock_polarity;
               end
            end
            ISPI_FIRST: begin
               // first edge: idle-to-active; sample here if phase is 0 and rx delay is off
               div_ff <= div_ff + 4'h1;
               smp_pend_ff <= 1'b0;
               if (div_ff == 4'h0 && !cfg_ff.clock_phase && !cfg_ff.rx_delay) begin
                  sh_rx_ff <= cfg_ff.bit_order ? {sh_rx_ff[6:0], bit_in}
                     : {bit_in, sh_rx_ff[7:1]};
               end
               if (div_ff == 4'h0 && cfg_ff.clock_phase && cfg_ff.rx_delay) begin
                  smp_pend_ff <= 1'b1;
               end
               if (div_ff == `ISPI_HALF_CYC) begin
                  div_ff <= 4'h0;
                  state_ff <= ISPI_SECOND;
                  sck_o <= cfg_ff.clock_polarity;
                  if (!cfg_ff.clock_phase) begin
                     // phase 0: shift on the trailing edge, leading edge sees settled data
                     mosi_o <= (bit_ff == 3'h7) ? out_bit(tx_mem[tx_idx_ff + 6'h01], 3'h0,
                        cfg_ff.bit_order) : out_bit(sh_tx_ff, bit_ff + 3'h1, cfg_ff.bit_order);
                  end
               end
            end
            ISPI_SECOND: begin
               div_ff <= div_ff + 4'h1;
               if (div_ff == 4'h0 && (cfg_ff.clock_phase ^ cfg_ff.rx_delay)) begin
                  // phase 0 with delay and phase 1 without delay sample here; phase 1 with delay only sets smp_pend_ff and is never sampled
                  sh_rx_ff <= cfg_ff.bit_order ? {sh_rx_ff[6:0], bit_in}
                     : {bit_in, sh_rx_ff[7:1]};
               end
               if (div_ff == `ISPI_HALF_CYC) begin
                  div_ff <= 4'h0;
                  bit_ff <= bit_ff + 3'h1;
                  state_ff <= ISPI_FIRST;
                  sck_o <= ~cfg_ff.clock_polarity;
                  if (cfg_ff.clock_phase) begin
                     mosi_o <= out_bit(sh_tx_ff, bit_ff + 3'h1, cfg_ff.bit_order);
                  end
                  if (bit_ff == 3'h7) begin
                     byte_n_ff <= byte_n_ff + 8'h01;
                     tx_idx_ff <= tx_idx_ff + 6'h01;
                     sh_tx_ff <= tx_mem[tx_idx_ff + 6'h01];
                     if (cfg_ff.clock_phase) begin
                        mosi_o <= out_bit(tx_mem[tx_idx_ff + 6'h01], 3'h0, cfg_ff.bit_order);
                     end
                     if (!cfg_ff.wiring && byte_n_ff + 8'h01 >= nbytes) begin
                        mosi_oe_o <= 1'b0;
                     end
                     if (cfg_ff.wiring || byte_n_ff >= nbytes) begin
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                     end
                     if (byte_n_ff + 8'h01 >= `ISPI_TXCNT_MAX) begin
                        state_ff <= ISPI_GAP;
                        sck_o <= cfg_ff.clock_polarity;
                     end
                  end
               end
            end
            ISPI_GAP: begin
               select_one_o <= ~link_one_ff.select_polarity;
               select_two_o <= ~link_two_ff.select_polarity;
               mosi_oe_o <= 1'b0;
               div_ff <= 4'h0;
               if (rep_ff == 8'h00) begin
                  state_ff <= ISPI_IDLE;
                  link_done_tgl_ff <= ~link_done_tgl_ff;
               end else begin
                  rep_ff <= rep_ff - 8'h01;
                  state_ff <= ISPI_LEAD;
               end
            end
            default: state_ff <= ISPI_IDLE;
         endcase
      end
   end

   // received bytes stored from the rx pointer
   always_ff @(posedge link_clk_i) begin
      if (state_ff == ISPI_SECOND && div_ff == `ISPI_HALF_CYC && bit_ff == 3'h7 &&
         (cfg_ff.wiring || byte_n_ff >= nbytes)) begin
         rx_mem[rx_idx_ff] <= sh_rx_ff;
      end
   end
endmodule

// File: ispi_consts.svh
// constants for the general spi channel: register offsets, fields, limits
// assumes inclusion by the core module, the checker and the bench
`ifndef ISPI_CONSTS_SVH
`define ISPI_CONSTS_SVH
// register indices as printed; byte address is four times the index
`define ISPI_IDX_START 16'h0430
`define ISPI_IDX_ENABLE 16'h0431
`define ISPI_IDX_TGTSEL 16'h0433
`define ISPI_IDX_REPEAT 16'h0435
`define ISPI_IDX_RXPTR 16'h0436
`define ISPI_IDX_TXPTR 16'h0437
`define ISPI_IDX_TXCNT 16'h043a
`define ISPI_IDX_TEMP 16'h0443
`define ISPI_IDX_LINK1 16'h0450
`define ISPI_IDX_LINK2 16'h0451
`define ISPI_IDX_STATUS 16'h0460
`define ISPI_IDX_TXBUF 16'h0500
`define ISPI_IDX_RXBUF 16'h0540
`define ISPI_TXBUF_DEPTH 48
`define ISPI_RXBUF_DEPTH 16
`define ISPI_TXPTR_MAX 8'h2e
`define ISPI_RXPTR_MAX 8'h0f
`define ISPI_REPEAT_MAX 8'h0f
`define ISPI_TXCNT_MAX 8'h30
`define ISPI_TGT_NONE 2'b00
`define ISPI_TGT_TWO 2'b10
`define ISPI_TGTSEL_LO 5
`define ISPI_TRIG_SRC_BIT 7
// link settings bits
`define ISPI_B_CPHA 0
`define ISPI_B_CPOL 1
`define ISPI_B_SPOL 2
`define ISPI_B_ORDER 3
`define ISPI_B_WIRE 4
`define ISPI_B_RXDLY 6
// last divider count of a serial clock half period; the half period lasts this plus one link clock cycles
`define ISPI_HALF_CYC 4'h2
`endif

// File: ispi_pkg.sv
// types for the general spi channel
// assumes ispi_consts.svh beside it
package ispi_pkg;
   typedef struct packed {
      logic rx_delay;
      logic wiring;
      logic bit_order;
      logic select_polarity;
      logic clock_polarity;
      logic clock_phase;
   } ispi_link_s;
   typedef struct packed {
      logic [1:0] target_select;
      logic [7:0] repeat_count;
      logic [7:0] rx_ptr;
      logic [7:0] tx_ptr;
      logic [7:0] tx_byte_count;
   } ispi_job_s;
   typedef enum logic [2:0] {
      ISPI_IDLE, ISPI_LEAD, ISPI_FIRST, ISPI_SECOND, ISPI_GAP
   } ispi_state_e;
endpackage

// File: ispi_core_sva.sv
// checker for the general spi channel, sees only the core's ports
// assumes settings are left alone while busy_o is high
`timescale 1ns/1ns
`include "ispi_consts.svh"
module ispi_core_sva
   import ispi_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic select_one_o,
   input wire logic select_two_o,
   input wire logic busy_o
);
   // ****
   // register shadow and checks
   // ****
   logic acc;
   logic [15:0] idx;
   logic en_ff;
   logic [1:0] tgt_ff;
   logic spol1_ff;
   logic spol2_ff;
   assign acc = psel_i && penable_i && pwrite_i && pready_o;
   assign idx = paddr_i[17:2];
   // shadow copies only, taken at the access edge like the slave
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         en_ff <= 1'b0;
         tgt_ff <= 2'b00;
         spol1_ff <= 1'b0;
         spol2_ff <= 1'b0;
      end else if (acc) begin
         if (idx == `ISPI_IDX_ENABLE) en_ff <= pwdata_i[0];
         if (idx == `ISPI_IDX_TGTSEL) tgt_ff <= pwdata_i[6:5];
         if (idx == `ISPI_IDX_LINK1) spol1_ff <= pwdata_i[`ISPI_B_SPOL];
         if (idx == `ISPI_IDX_LINK2) spol2_ff <= pwdata_i[`ISPI_B_SPOL];
      end
   end
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_b_i);
   chk_ready_setup: assert property (psel_i && !penable_i |=> pready_o)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held");
   chk_run_enabled: assert property ($rose(busy_o) |-> en_ff)
      else $error("run while disabled");
   chk_zero_idle: assert property (acc && idx == `ISPI_IDX_START && !pwdata_i[0] && !busy_o
      |=> !busy_o [*8])
      else $error("zero write started");
   chk_one_starts: assert property (acc && idx == `ISPI_IDX_START && pwdata_i[0] && en_ff
      && tgt_ff != 2'b00 && !busy_o |-> ##[1:40] busy_o)
      else $error("start not taken");
   chk_busy_holds: assert property ($rose(busy_o) |=> busy_o [*8])
      else $error("busy too short");
   chk_sel_none: assert property (busy_o && tgt_ff == 2'b00
      |-> select_one_o != spol1_ff && select_two_o != spol2_ff)
      else $error("select with no target");
   chk_two_only: assert property (busy_o && tgt_ff == 2'b10 |-> select_one_o != spol1_ff)
      else $error("slave one selected");
   chk_one_only: assert property (busy_o && tgt_ff[0] |-> select_two_o != spol2_ff)
      else $error("slave two selected");
endmodule

bind ispi_core ispi_core_sva u_ispi_core_sva (
   .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .select_one_o(select_one_o), .select_two_o(select_two_o), .busy_o(busy_o)
);

// File: ispi_slave_model.sv
// behavioural spi slave on one select line
// assumes the bench hands it the same link settings as the device
`timescale 1ns/1ns
module ispi_slave_model
   import ispi_pkg::*;
(
   input wire logic sck_i,
   input wire logic sel_i,
   input wire logic mosi_i,
   input wire logic clr_i,
   input wire ispi_link_s cfg_i,
   input wire logic [7:0] pat_i,
   output logic miso_o,
   output logic [7:0] frames_o,
   output logic [15:0] got_o
);
   // ****
   // slave behaviour
   // ****
   int n_in = 0;
   int n_out = 0;
   int pos;
   wire logic act = sel_i == cfg_i.select_polarity;
   // pattern repeats every 16 bytes, so a wrapping rx slot still compares
   function automatic logic bit_of(input int n);
      logic [7:0] b;
      b = pat_i ^ {4'h0, 4'(n / 8)};
      return cfg_i.bit_order ? b[7 - n % 8] : b[n % 8];
   endfunction
   initial begin
      miso_o = 1'b0;
      frames_o = 8'h00;
      got_o = 16'h0000;
   end
   always @(posedge clr_i) frames_o = 8'h00;
   always @(posedge act) begin
      frames_o = frames_o + 8'h01;
      n_in = 0;
      n_out = cfg_i.clock_phase ? 0 : 1;
      miso_o = cfg_i.clock_phase ? ~miso_o : bit_of(0);
   end
   // released line shows the inverse, never the last bit
   always @(negedge act) miso_o = ~miso_o;
   always @(sck_i) begin
      if (act && ((sck_i != cfg_i.clock_polarity) ^ cfg_i.clock_phase)) begin
         pos = (n_in < 8 ? 8 : 0) + (cfg_i.bit_order ? 7 - n_in % 8 : n_in % 8);
         if (n_in < 16) got_o[pos] = mosi_i;
         n_in++;
      end else if (act) begin
         miso_o = bit_of(n_out);
         n_out++;
      end
   end
endmodule

// File: ispi_core_bench.sv
// self-checking bench for the general spi channel
// assumes two slave models on the link, 4-wire, no rx delay
`timescale 1ns/1ns
`include "ispi_consts.svh"
module ispi_core_bench
   import ispi_pkg::*;
;
   // ****
   // stimulus and checks
   // ****
   logic ref_clk_i = 1'b0;
   logic link_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic ext_trigger_i = 1'b0;
   logic clr = 1'b0;
   logic [31:0] paddr_i = 32'h0000_0000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [7:0] pat1 = 8'h00;
   logic [7:0] pat2 = 8'h00;
   logic [31:0] prdata_o, rd;
   logic pready_o, pslverr_o, sck_o, select_one_o, select_two_o, mosi_o, busy_o;
   logic m1, m2, err;
   logic [7:0] fr1, fr2, rep, v;
   logic [15:0] got1, got2;
   logic [7:0] txb [48];
   logic [15:0] ridx [7] = '{`ISPI_IDX_REPEAT, `ISPI_IDX_RXPTR, `ISPI_IDX_TXPTR,
      `ISPI_IDX_TXCNT, `ISPI_IDX_TEMP, `ISPI_IDX_LINK1, `ISPI_IDX_LINK2};
   logic [7:0] lim [7] = '{`ISPI_REPEAT_MAX, `ISPI_RXPTR_MAX, `ISPI_TXPTR_MAX,
      `ISPI_TXCNT_MAX, 8'h0f, 8'h5f, 8'h5f};
   ispi_link_s cfg1 = '0;
   ispi_link_s cfg2 = '0;
   int failures = 0;
   int cmp_count = 0;
   int seed = 32'h2ed1_1cb1;
   int tp, rp;
   wire logic miso_i = (select_one_o == cfg1.select_polarity) ? m1 : m2;
   ispi_core u_ispi_core (
      .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .link_clk_i(link_clk_i),
      .ext_trigger_i(ext_trigger_i), .sck_o(sck_o), .select_one_o(select_one_o),
      .select_two_o(select_two_o), .mosi_o(mosi_o), .mosi_oe_o(), .miso_i(miso_i),
      .busy_o(busy_o));
   ispi_slave_model u_ispi_slave_model (.sck_i(sck_o), .sel_i(select_one_o), .mosi_i(mosi_o),
      .clr_i(clr), .cfg_i(cfg1), .pat_i(pat1), .miso_o(m1), .frames_o(fr1), .got_o(got1));
   ispi_slave_model u_ispi_slave_model_2 (.sck_i(sck_o), .sel_i(select_two_o), .mosi_i(mosi_o),
      .clr_i(clr), .cfg_i(cfg2), .pat_i(pat2), .miso_o(m2), .frames_o(fr2), .got_o(got2));
   initial forever #25 ref_clk_i = ~ref_clk_i;
   initial begin
      #7;
      forever #6 link_clk_i = ~link_clk_i;
   end
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      psel_i <= 1'b1;
      pwrite_i <= wr;
      paddr_i <= {14'h0000, idx, 2'b00};
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      // ready is looked at mid-cycle, settled, ahead of the edge that completes the access
      @(negedge ref_clk_i);
      while (pready_o !== 1'b1 && n < 50) begin
         @(negedge ref_clk_i);
         n++;
      end
      if (pready_o !== 1'b1) failures++;
      rd = prdata_o;
      err = pslverr_o;
      @(posedge ref_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // a missing rise of busy is not counted as a failure, so only the fall is bounded hard
   task automatic wait_done();
      int n;
      n = 0;
      while (busy_o !== 1'b1 && n < 40) begin
         @(posedge ref_clk_i);
         n++;
      end
      n = 0;
      while (busy_o !== 1'b0 && n < 30000) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (busy_o !== 1'b0) failures++;
      repeat (20) @(posedge ref_clk_i);
   endtask
   function automatic logic [7:0] exp_frames(input logic [1:0] t, input logic two,
      input logic [7:0] n);
      if (t == `ISPI_TGT_NONE || (t == `ISPI_TGT_TWO) != two) return 8'h00;
      return n + 8'h01;
   endfunction
   function automatic logic [31:0] link_word(input ispi_link_s c);
      return {25'h0, c.rx_delay, 1'b0, c[4:0]};
   endfunction
   task automatic complete_run();
      $display("compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      failures++;
      complete_run();
   end
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int k = 0; k < 14; k++) begin
         v = lim[k % 7];
         if (k >= 7) v = (k % 7 > 4) ? v & 8'($random(seed)) : 8'({$random(seed)} % (v + 1));
         apb(1'b1, ridx[k % 7], {24'h00_0000, v});
         apb(1'b0, ridx[k % 7], 32'h0000_0000);
         chk(rd, {24'h00_0000, v});
      end
      apb(1'b0, 16'h0470, 32'h0000_0000);
      chk({rd[31:1], err}, 32'h0000_0001);
      for (int i = 0; i < 48; i++) begin
         txb[i] = 8'($random(seed));
         apb(1'b1, `ISPI_IDX_TXBUF + 16'(i), {24'h00_0000, txb[i]});
      end
      $display("test registers done");
      apb(1'b1, `ISPI_IDX_TGTSEL, 32'h0000_0020);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, `ISPI_IDX_ENABLE, 32'(k));
         apb(1'b1, `ISPI_IDX_START, 32'(1 - k));
         repeat (60) @(posedge ref_clk_i);
         chk(32'(busy_o), 32'h0000_0000);
      end
      $display("test refusal done");
      for (int t = 0; t < 4; t++) begin
         cfg1 = {2'b01, 4'($random(seed))};
         cfg2 = {2'b01, 4'($random(seed))};
         pat1 = 8'($random(seed));
         pat2 = 8'($random(seed));
         rep = (t == 3) ? 8'h0f : 8'({$random(seed)} % 3);
         tp = (t == 3) ? 46 : {$random(seed)} % 47;
         rp = (t == 3) ? 15 : {$random(seed)} % 16;
         apb(1'b1, `ISPI_IDX_LINK1, link_word(cfg1));
         apb(1'b1, `ISPI_IDX_LINK2, link_word(cfg2));
         apb(1'b1, `ISPI_IDX_TGTSEL, {25'h0, 2'(t), 5'h00});
         apb(1'b1, `ISPI_IDX_REPEAT, {24'h00_0000, rep});
         apb(1'b1, `ISPI_IDX_RXPTR, 32'(rp));
         apb(1'b1, `ISPI_IDX_TXPTR, 32'(tp));
         apb(1'b1, `ISPI_IDX_ENABLE, 32'h0000_0001);
         repeat (20) @(posedge ref_clk_i);
         clr <= 1'b1;
         @(posedge ref_clk_i);
         clr <= 1'b0;
         apb(1'b1, `ISPI_IDX_START, 32'h0000_0001);
         wait_done();
         chk(32'(fr1), 32'(exp_frames(2'(t), 1'b0, rep)));
         chk(32'(fr2), 32'(exp_frames(2'(t), 1'b1, rep)));
         if (t != 0) begin
            chk(32'(t == 2 ? got2 : got1), {16'h0000, txb[tp], txb[tp + 1]});
            chk(32'(sck_o), 32'(cfg1.clock_polarity));
            apb(1'b0, `ISPI_IDX_RXBUF + 16'(rp), 32'h0000_0000);
            chk(rd, {24'h00_0000, t == 2 ? pat2 : pat1});
         end
         $display("test target %0d done", t);
      end
      complete_run();
   end
endmodule
